// File: include/spiq_pkg.sv
package spiq_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] SPIQ_ADDR_CONTROL = 16'h1028;
   localparam logic [15:0] SPIQ_ADDR_STATUS = 16'h1029;
   localparam logic [15:0] SPIQ_ADDR_DATA = 16'h102a;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int SPIQ_CTL_IRQ_EN = 7;
   localparam int SPIQ_CTL_PORT_EN = 6;
   localparam int SPIQ_CTL_OPEN_DRAIN = 5;
   localparam int SPIQ_CTL_MASTER = 4;
   localparam int SPIQ_CTL_CLOCK_IDLE_POLARITY = 3;
   localparam int SPIQ_CTL_CLOCK_PHASE_SELECT = 2;
   localparam int SPIQ_CTL_RATE_HI = 1;
   localparam int SPIQ_CTL_RATE_LO = 0;

   // ----------------------------------------------------------------
   // Status field positions
   // ----------------------------------------------------------------
   localparam int SPIQ_STS_DONE = 7;
   localparam int SPIQ_STS_WRITE_COLLISION_FLAG = 6;
   localparam int SPIQ_STS_MODE_FAULT_FLAG = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] SPIQ_CONTROL_RESET = 8'h04;
   localparam logic [7:0] SPIQ_STATUS_RESET = 8'h00;
   localparam logic [7:0] SPIQ_DATA_RESET = 8'h00;
   localparam logic [7:0] SPIQ_READ_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // Timing: clocks per half serial clock period for each rate code
   // ----------------------------------------------------------------
   localparam logic [4:0] SPIQ_HALF_DIV2 = 5'h01;
   localparam logic [4:0] SPIQ_HALF_DIV4 = 5'h02;
   localparam logic [4:0] SPIQ_HALF_DIV16 = 5'h08;
   localparam logic [4:0] SPIQ_HALF_DIV32 = 5'h10;
   localparam logic [3:0] SPIQ_LAST_EDGE = 4'hf;

   typedef enum logic [0:0] {
      SPIQ_IDLE = 1'b0,
      SPIQ_SHIFT = 1'b1
   } spiq_state_t;

   function automatic logic [4:0] spiq_half_count(input logic [1:0] rate);
      unique case (rate)
         2'b00: spiq_half_count = SPIQ_HALF_DIV2;
         2'b01: spiq_half_count = SPIQ_HALF_DIV4;
         2'b10: spiq_half_count = SPIQ_HALF_DIV16;
         2'b11: spiq_half_count = SPIQ_HALF_DIV32;
      endcase
   endfunction : spiq_half_count

endpackage : spiq_pkg

// File: rtl/spiq_rate_gen.sv
`timescale 1ns/1ps
module spiq_rate_gen
   import spiq_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [1:0] rate,
   // Half period strobe
   output logic tick
);

   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   // ----------------------------------------------------------------
   // Divider: one tick per half serial clock period
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cnt = 5'h00;
      nxt_tick = 1'b0;
      if (run) begin
         if (cnt_ff + 5'h01 >= spiq_half_count(rate)) begin
            nxt_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 5'h00;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule : spiq_rate_gen

// File: rtl/spiq_master.sv
// Notes on behaviour
// - Byte exchange end sets done flag bit 7
// - Data write while busy sets collision bit 6
// - Status read then data access clears both
// - Master with slave select low sets fault
// - Status read then control write clears fault
// - Master data write starts full duplex exchange
// - Status bits 7,6,4 used; others zero
// - Control layout and reset value 0000_01xx
// - Link runs polarity 0, phase 0
// - Twelve bit code is straight binary unipolar
// - Interrupt on done or fault when enabled
// - Serial clock idles at chosen polarity
// - Rate bits divide clock 2,4,16,32
`timescale 1ns/1ps
module spiq_master
   import spiq_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Processor register port
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // Serial pins
   output logic sck_out,
   output logic sck_oe,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   input wire logic slave_sel_n_in,
   // Interrupt request
   output logic irq_n
);

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [1:0] miso_sync_ff;
   logic [1:0] ss_sync_ff;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         miso_sync_ff <= 2'b00;
         ss_sync_ff <= 2'b11;
      end else begin
         miso_sync_ff <= {miso_sync_ff[0], miso_in};
         ss_sync_ff <= {ss_sync_ff[0], slave_sel_n_in};
      end
   end

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic wr_ctl, rd_sts, wr_data, acc_data;
   assign wr_ctl = bus_wr && bus_addr == SPIQ_ADDR_CONTROL;
   assign rd_sts = bus_rd && bus_addr == SPIQ_ADDR_STATUS;
   assign wr_data = bus_wr && bus_addr == SPIQ_ADDR_DATA;
   assign acc_data = (bus_wr || bus_rd) && bus_addr == SPIQ_ADDR_DATA;
   // ----------------------------------------------------------------
   // Registers and flags
   // ----------------------------------------------------------------
   logic [7:0] ctl_ff, nxt_ctl;
   logic done_ff, nxt_done;
   logic write_collision_flag_ff, nxt_write_collision_flag;
   logic mode_fault_flag_ff, nxt_mode_fault_flag;
   logic arm_xfer_ff, nxt_arm_xfer;
   logic arm_mode_fault_flag_ff, nxt_arm_mode_fault_flag;
   logic [7:0] rx_buf_ff, nxt_rx_buf, rx_sr_next;
   logic busy, finish, start, fault;

   assign fault = ctl_ff[SPIQ_CTL_MASTER] && ctl_ff[SPIQ_CTL_PORT_EN] && !ss_sync_ff[1];
   assign start = wr_data && !busy && ctl_ff[SPIQ_CTL_MASTER]
                  && ctl_ff[SPIQ_CTL_PORT_EN] && !mode_fault_flag_ff;

   always_comb begin
      nxt_ctl = ctl_ff;
      nxt_done = done_ff;
      nxt_write_collision_flag = write_collision_flag_ff;
      nxt_mode_fault_flag = mode_fault_flag_ff;
      nxt_arm_xfer = arm_xfer_ff;
      nxt_arm_mode_fault_flag = arm_mode_fault_flag_ff;
      nxt_rx_buf = rx_buf_ff;
      if (wr_ctl) begin
         nxt_ctl = bus_wdata;
      end
      // Clears first so that a same-cycle set below wins
      if (acc_data && arm_xfer_ff) begin
         nxt_done = 1'b0;
         nxt_write_collision_flag = 1'b0;
         nxt_arm_xfer = 1'b0;
      end
      if (wr_ctl && arm_mode_fault_flag_ff) begin
         nxt_mode_fault_flag = 1'b0;
         nxt_arm_mode_fault_flag = 1'b0;
      end
      if (rd_sts && (done_ff || write_collision_flag_ff)) begin
         nxt_arm_xfer = 1'b1;
      end
      if (rd_sts && mode_fault_flag_ff) begin
         nxt_arm_mode_fault_flag = 1'b1;
      end
      if (finish) begin
         nxt_done = 1'b1;
         nxt_rx_buf = rx_sr_next;
      end
      if (wr_data && busy) begin
         nxt_write_collision_flag = 1'b1;
      end
      if (fault) begin
         nxt_mode_fault_flag = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_ff <= SPIQ_CONTROL_RESET;
         done_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         mode_fault_flag_ff <= 1'b0;
         arm_xfer_ff <= 1'b0;
         arm_mode_fault_flag_ff <= 1'b0;
         rx_buf_ff <= SPIQ_DATA_RESET;
      end else begin
         ctl_ff <= nxt_ctl;
         done_ff <= nxt_done;
         write_collision_flag_ff <= nxt_write_collision_flag;
         mode_fault_flag_ff <= nxt_mode_fault_flag;
         arm_xfer_ff <= nxt_arm_xfer;
         arm_mode_fault_flag_ff <= nxt_arm_mode_fault_flag;
         rx_buf_ff <= nxt_rx_buf;
      end
   end

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   spiq_state_t state_ff, nxt_state;
   logic [7:0] sr_ff, nxt_sr;
   logic [3:0] edge_ff, nxt_edge;
   logic sck_lvl_ff, nxt_sck_lvl;
   logic mosi_ff, nxt_mosi;
   logic rx_bit_ff, nxt_rx_bit;
   logic tick, clock_phase_select;

   assign busy = state_ff == SPIQ_SHIFT;
   assign clock_phase_select = ctl_ff[SPIQ_CTL_CLOCK_PHASE_SELECT];
   // Mode 0 samples on the trailing edge; sync and pin lag make the leading one stale
   assign rx_sr_next = {sr_ff[6:0], clock_phase_select ? rx_bit_ff : miso_sync_ff[1]};
   assign finish = busy && tick && edge_ff == SPIQ_LAST_EDGE;
   spiq_rate_gen u_rate (
      .clock(clock),
      .rst_n(rst_n),
      .run(busy),
      .rate(ctl_ff[SPIQ_CTL_RATE_HI:SPIQ_CTL_RATE_LO]),
      .tick(tick)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_sr = sr_ff;
      nxt_edge = edge_ff;
      nxt_sck_lvl = sck_lvl_ff;
      nxt_mosi = mosi_ff;
      nxt_rx_bit = rx_bit_ff;
      unique case (state_ff)
         SPIQ_IDLE: begin
            nxt_sck_lvl = 1'b0;
            if (start) begin
               nxt_state = SPIQ_SHIFT;
               nxt_sr = bus_wdata;
               nxt_edge = 4'h0;
               if (!clock_phase_select) begin
                  nxt_mosi = bus_wdata[7];
               end
            end
         end
         SPIQ_SHIFT: begin
            if (fault) begin
               // A fault aborts the byte; done is set only if the last edge ticks in that same cycle
               nxt_state = SPIQ_IDLE;
               nxt_sck_lvl = 1'b0;
            end else if (tick) begin
               nxt_sck_lvl = !sck_lvl_ff;
               nxt_edge = edge_ff + 4'h1;
               if (!edge_ff[0]) begin
                  // Leading edge
                  nxt_rx_bit = miso_sync_ff[1];
                  if (clock_phase_select) begin
                     nxt_mosi = sr_ff[7];
                  end
               end else begin
                  // Trailing edge
                  nxt_sr = rx_sr_next;
                  if (!clock_phase_select && edge_ff != SPIQ_LAST_EDGE) begin
                     nxt_mosi = sr_ff[6];
                  end
               end
               if (edge_ff == SPIQ_LAST_EDGE) begin
                  nxt_state = SPIQ_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SPIQ_IDLE;
         sr_ff <= SPIQ_DATA_RESET;
         edge_ff <= 4'h0;
         sck_lvl_ff <= 1'b0;
         mosi_ff <= 1'b1;
         rx_bit_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sr_ff <= nxt_sr;
         edge_ff <= nxt_edge;
         sck_lvl_ff <= nxt_sck_lvl;
         mosi_ff <= nxt_mosi;
         rx_bit_ff <= nxt_rx_bit;
      end
   end

   // ----------------------------------------------------------------
   // Pins, read data and interrupt
   // ----------------------------------------------------------------
   logic sck_out_ff, nxt_sck_out, sck_oe_ff, nxt_sck_oe;
   logic mosi_out_ff, nxt_mosi_out, mosi_oe_ff, nxt_mosi_oe;
   logic [7:0] rdata_ff, nxt_rdata;
   logic irq_n_ff, nxt_irq_n;
   logic drive;

   // Open drain mode only pulls low; the board supplies the high level
   assign drive = ctl_ff[SPIQ_CTL_PORT_EN] && ctl_ff[SPIQ_CTL_MASTER] && !mode_fault_flag_ff;
   always_comb begin
      nxt_sck_out = sck_lvl_ff ^ ctl_ff[SPIQ_CTL_CLOCK_IDLE_POLARITY];
      nxt_mosi_out = mosi_ff;
      nxt_sck_oe = drive && (!ctl_ff[SPIQ_CTL_OPEN_DRAIN] || !nxt_sck_out);
      nxt_mosi_oe = drive && (!ctl_ff[SPIQ_CTL_OPEN_DRAIN] || !nxt_mosi_out);
      nxt_rdata = SPIQ_READ_UNMAPPED;
      if (bus_rd) begin
         unique case (bus_addr)
            SPIQ_ADDR_CONTROL: nxt_rdata = ctl_ff;
            SPIQ_ADDR_STATUS: begin
               nxt_rdata = SPIQ_STATUS_RESET;
               nxt_rdata[SPIQ_STS_DONE] = done_ff;
               nxt_rdata[SPIQ_STS_WRITE_COLLISION_FLAG] = write_collision_flag_ff;
               nxt_rdata[SPIQ_STS_MODE_FAULT_FLAG] = mode_fault_flag_ff;
            end
            SPIQ_ADDR_DATA: nxt_rdata = rx_buf_ff;
            default: nxt_rdata = SPIQ_READ_UNMAPPED;
         endcase
      end
      nxt_irq_n = !(ctl_ff[SPIQ_CTL_IRQ_EN] && (nxt_done || nxt_mode_fault_flag));
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_out_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         mosi_out_ff <= 1'b1;
         mosi_oe_ff <= 1'b0;
         rdata_ff <= SPIQ_READ_UNMAPPED;
         irq_n_ff <= 1'b1;
      end else begin
         sck_out_ff <= nxt_sck_out;
         sck_oe_ff <= nxt_sck_oe;
         mosi_out_ff <= nxt_mosi_out;
         mosi_oe_ff <= nxt_mosi_oe;
         rdata_ff <= nxt_rdata;
         irq_n_ff <= nxt_irq_n;
      end
   end

   assign sck_out = sck_out_ff;
   assign sck_oe = sck_oe_ff;
   assign mosi_out = mosi_out_ff;
   assign mosi_oe = mosi_oe_ff;
   assign bus_rdata = rdata_ff;
   assign irq_n = irq_n_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_done_on_finish: assert property (finish |=> done_ff)
      else $error("done flag not set after exchange");
   chk_write_collision_flag_on_busy_wr: assert property (wr_data && busy |=> write_collision_flag_ff)
      else $error("collision flag missing");
   chk_flag_clear_seq: assert property (
      done_ff && !arm_xfer_ff && !finish |=> done_ff)
      else $error("done flag cleared without status read");
   chk_mode_fault_flag_on_fault: assert property (fault |=> mode_fault_flag_ff)
      else $error("mode fault not flagged");
   chk_mode_fault_flag_hold: assert property (
      mode_fault_flag_ff && !(wr_ctl && arm_mode_fault_flag_ff) |=> mode_fault_flag_ff)
      else $error("mode fault cleared early");
   chk_start_busy: assert property (start |=> busy)
      else $error("data write did not start exchange");
   chk_status_zero_bits: assert property (
      $past(rd_sts) |-> bus_rdata[5] == 1'b0 && bus_rdata[3:0] == 4'h0)
      else $error("unused status bits not zero");
   chk_sck_idle: assert property (
      !busy && drive && $stable(ctl_ff) [*2] |=> sck_out == $past(ctl_ff[SPIQ_CTL_CLOCK_IDLE_POLARITY]))
      else $error("serial clock not idle at polarity");
   chk_div2_length: assert property (
      start && ctl_ff[1:0] == 2'b00 |-> ##17 (finish || !busy))
      else $error("divide by two exchange length wrong");
   chk_irq_done: assert property (
      $past(ctl_ff[SPIQ_CTL_IRQ_EN]) && $rose(done_ff) |-> !irq_n)
      else $error("interrupt not raised");
   cov_exchange: cover property (start ##[1:600] finish);
   cov_collision: cover property (busy && wr_data);
   cov_fault: cover property (fault ##1 rd_sts ##[1:100] wr_ctl);
endmodule : spiq_master

// File: bench/spiq_dac_model.sv
`timescale 1ns/1ps
module spiq_dac_model (
   // Serial pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic cs_n,
   output logic miso,
   // Latched word
   output logic [15:0] word,
   output logic [11:0] code
);
   // ---------------------------------------------
   // Slave shifter, mode 0
   // ---------------------------------------------
   logic [15:0] shift_in;
   logic [15:0] reply;
   initial begin
      shift_in = 16'h0000;
      reply = 16'hc35a;
      word = 16'h0000;
      miso = 1'b1;
   end
   always @(negedge cs_n) begin
      reply = 16'hc35a;
      miso = reply[15];
   end
   // Sample on the rising edge, change on the falling one
   always @(posedge sck) if (!cs_n) shift_in = {shift_in[14:0], mosi};
   always @(negedge sck) if (!cs_n) begin
      reply = {reply[14:0], 1'b0};
      miso = reply[15];
   end
   // Released line shows the inverse so a late sample cannot look right
   always @(posedge cs_n) begin
      word = shift_in;
      miso = ~miso;
   end
   assign code = word[11:0];
endmodule : spiq_dac_model

// File: bench/tb_spi_master_dac_loader.sv
`timescale 1ns/1ps
module tb_spi_master_dac_loader;
   import spiq_pkg::*;
   logic clock, reset_n, bus_wr, bus_rd, slave_sel_n_in, cs_n, sck_q;
   logic [15:0] bus_addr, dac_word;
   logic [11:0] dac_code;
   logic [7:0] bus_wdata, bus_rdata, v;
   logic sck_out, sck_oe, mosi_out, mosi_oe, irq_n, miso, sck_pin, mosi_pin;
   int error_cnt, comparisons, rises, hi_cnt;
   int half_tbl[4] = '{1, 2, 8, 16};
   assign sck_pin = sck_oe ? sck_out : 1'b1;
   assign mosi_pin = mosi_oe ? mosi_out : 1'b1;
   spiq_master uut (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .sck_out(sck_out),
      .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso),
      .slave_sel_n_in(slave_sel_n_in), .irq_n(irq_n));
   spiq_dac_model dac (.sck(sck_pin), .mosi(mosi_pin), .cs_n(cs_n), .miso(miso),
      .word(dac_word), .code(dac_code));
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      if (sck_pin && !sck_q) rises++;
      if (sck_pin) hi_cnt++;
      sck_q = sck_pin;
   end
   // ---------------------------------------------
   // Access tasks
   // ---------------------------------------------
   task automatic tally_and_finish();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(posedge clock);
      #1;
      bus_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge clock);
      #1;
      bus_rd = 1'b0;
      d = bus_rdata;
   endtask : rd
   // Polling is bounded; a stuck exchange ends the run
   task automatic wait_done(output logic [7:0] s);
      for (int i = 0; i < 200; i++) begin
         rd(SPIQ_ADDR_STATUS, s);
         if (s[SPIQ_STS_DONE] === 1'b1) return;
      end
      error_cnt++;
      $display("ERROR at %0t: exchange never completed", $time);
      tally_and_finish();
   endtask : wait_done
   task automatic set_cs(input logic lvl);
      @(posedge clock);
      #1;
      cs_n = lvl;
   endtask : set_cs
   // ---------------------------------------------
   // Sequence
   // ---------------------------------------------
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      slave_sel_n_in = 1'b1;
      cs_n = 1'b1;
      sck_q = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (12) @(posedge clock);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clock);
      rd(SPIQ_ADDR_CONTROL, v);
      check(v, SPIQ_CONTROL_RESET);
      rd(SPIQ_ADDR_STATUS, v);
      check(v, 8'h00);
      rd(16'h1030, v);
      check(v, SPIQ_READ_UNMAPPED);
      wr(SPIQ_ADDR_CONTROL, 8'h51);
      rd(SPIQ_ADDR_CONTROL, v);
      check(v, 8'h51);
      check(sck_pin, 1'b0);
      set_cs(1'b0);
      wr(SPIQ_ADDR_DATA, 8'h74);
      wr(SPIQ_ADDR_DATA, 8'h99);
      wait_done(v);
      check(v, 8'hc0);
      rd(SPIQ_ADDR_DATA, v);
      check(v, 8'hc3);
      rd(SPIQ_ADDR_STATUS, v);
      check(v, 8'h00);
      check(irq_n, 1'b1);
      rises = 0;
      wr(SPIQ_ADDR_DATA, 8'h00);
      wait_done(v);
      check(v, 8'h80);
      rd(SPIQ_ADDR_DATA, v);
      check(v, 8'h5a);
      check(rises, 8);
      set_cs(1'b1);
      #1;
      check(dac_word, 16'h7400);
      check(dac_code, 12'h400);
      for (int r = 0; r < 4; r++) begin
         wr(SPIQ_ADDR_CONTROL, {6'b110100, r[1:0]});
         set_cs(1'b0);
         hi_cnt = 0;
         wr(SPIQ_ADDR_DATA, 8'ha5);
         wait_done(v);
         check(irq_n, 1'b0);
         check(hi_cnt, 8 * half_tbl[r]);
         rd(SPIQ_ADDR_DATA, v);
         set_cs(1'b1);
         #1;
         check(dac_word[7:0], 8'ha5);
         check(irq_n, 1'b1);
      end
      wr(SPIQ_ADDR_CONTROL, 8'h58);
      repeat (3) @(posedge clock);
      #1;
      check(sck_out, 1'b1);
      // Open drain lets the idle-high clock and the high data bit float up
      wr(SPIQ_ADDR_CONTROL, 8'h78);
      repeat (3) @(posedge clock);
      #1;
      check(sck_oe, 1'b0);
      check(sck_pin, 1'b1);
      check(mosi_oe, 1'b0);
      wr(SPIQ_ADDR_CONTROL, 8'h50);
      @(posedge clock);
      #1;
      slave_sel_n_in = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      slave_sel_n_in = 1'b1;
      rd(SPIQ_ADDR_STATUS, v);
      check(v, 8'h10);
      check(sck_oe, 1'b0);
      // A data write under fault must not start anything
      rises = 0;
      wr(SPIQ_ADDR_DATA, 8'h11);
      repeat (30) @(posedge clock);
      check(rises, 0);
      rd(SPIQ_ADDR_DATA, v);
      check(v, 8'hc3);
      rd(SPIQ_ADDR_STATUS, v);
      check(v, 8'h10);
      wr(SPIQ_ADDR_CONTROL, 8'h50);
      rd(SPIQ_ADDR_STATUS, v);
      check(v, 8'h00);
      tally_and_finish();
   end
endmodule : tb_spi_master_dac_loader
